// ===== design/sfr_start_ctrl.sv
// Purpose: Start gating, fault trip and reset control of a soft starter
// Assumes: Protection conditions and settings come from logic on sys_clk
// Notes:   Time settings are in tenths of a second, counted by a tick enable
//
// Notes on behaviour
// - Edge mode: a held start after a trip is ignored until re-asserted.
// - The start release-and-reapply demand in edge mode ignores the reset mode.
// - Edge restart needs no trip, permissive, no cool-down inhibit and a fresh edge, in any reset mode.
// - Reset mode: 0 manual, 1 automatic, 2 one reset at power-up.
// - Manual mode clears trips only on panel, face or terminal reset press.
// - Automatic mode clears trips by itself without any reset request.
// - Power-up mode resets once after initialisation, then acts as manual.
// - Automatic reset happens once the delay expires and the condition is gone.
// - The auto-reset delay timer starts as soon as a fault is seen.
// - A still-present fault at expiry keeps the auto-reset attempt pending.
// - Auto-reset delay accepts 0.1 to 600 seconds, default 0.1.
// - Successful auto resets are counted; power cycling clears the count.
// - Limit up to 10000; at the limit auto reset stops, manual needed.
// - Manual reset zeroes the count; a zero limit disables limiting.
// - Warnings need no reset and drop when their condition goes away.
// - Status is stopped, ramping, jogging, bypassed, faulted or warning.
// - Access levels read-only, basic, all; both passwords default to zero.
// - Panel detach is harmless unless the removable setting is off or a panel start is running: then trip.
// - Detaching the panel while running from a panel start trips.
// - Starts and runs need permissive; dropping permissive stops the motor.
// - Overload cool-down inhibits restart and survives control power loss.
// - Bypass contactors cycle at random and close one after another.
// - Sense mode follows the front switch and is reported.
// - Level mode restarts after a fault in auto mode while start is held.
module sfr_start_ctrl #(
  parameter int unsigned TICK_CYCLES    = sfr_pkg::TICK_CYCLES,
  parameter int unsigned STAGGER_CYCLES = sfr_pkg::STAGGER_CYCLES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        start_pin,
  input  wire logic                        permissive_pin,
  input  wire logic                        jog_pin,
  input  wire logic                        term_reset_pin,
  input  wire logic                        panel_reset_pin,
  input  wire logic                        face_reset_pin,
  input  wire logic                        panel_start_pin,
  input  wire logic                        operator_panel_present,
  input  wire logic                        sense_select_switch,
  input  wire logic [1:0]                  reset_mode,
  input  wire logic [sfr_pkg::DLY_W-1:0]   reset_delay,
  input  wire logic [sfr_pkg::CNT_W-1:0]   reset_limit,
  input  wire logic                        panel_removable_en,
  input  wire logic                        init_done,
  input  wire logic                        fault_cond,
  input  wire logic                        warn_cond,
  input  wire logic                        at_speed,
  input  wire logic                        overload_trip,
  input  wire logic [sfr_pkg::COOL_W-1:0]  cooldown_time,
  input  wire logic [sfr_pkg::COOL_W-1:0]  cooldown_restore,
  input  wire logic                        pw_submit,
  input  wire logic                        pw_change,
  input  wire logic [1:0]                  pw_level,
  input  wire logic [sfr_pkg::PW_W-1:0]    pw_value,
  output logic                             ramp_running,
  output logic                             jog_running,
  output logic [sfr_pkg::NBYP-1:0]         bypass_close,
  output sfr_pkg::sfr_status_t             motor_status,
  output logic                             fault_trip,
  output logic                             warn_active,
  output logic                             sense_is_level,
  output logic [sfr_pkg::CNT_W-1:0]        auto_reset_count,
  output logic [sfr_pkg::COOL_W-1:0]       cooldown_remain,
  output logic                             restart_inhibit,
  output logic [1:0]                       access_level
);

  typedef struct packed {
    logic [sfr_pkg::TICK_W-1:0] tick_cnt;
    logic                       tick;
    sfr_pkg::sfr_state_t        st;
    logic                       trip;
    logic                       from_panel;
    logic                       after_fault;
    logic [sfr_pkg::DLY_W-1:0]  dly_cnt;
    logic                       dly_done;
    logic [sfr_pkg::CNT_W-1:0]  rst_cnt;
    logic                       init_prev;
    logic                       pu_done;
    logic [sfr_pkg::COOL_W-1:0] cool;
    logic                       cool_loaded;
    logic                       panel_prev;
    logic [sfr_pkg::LFSR_W-1:0] lfsr;
    logic [sfr_pkg::COOL_W-1:0] cyc_cnt;
    logic [sfr_pkg::NBYP-1:0]   byp;
    logic [sfr_pkg::STG_W-1:0]  stg_cnt;
    sfr_pkg::sfr_status_t       status;
    logic                       ramp_on;
    logic                       jog_on;
    logic                       inh;
    logic                       warn;
    logic                       sense_lvl;
    logic [1:0]                 lvl;
    logic [sfr_pkg::PW_W-1:0]   pw_basic;
    logic [sfr_pkg::PW_W-1:0]   pw_all;
  } sfr_state_s_t;

  sfr_state_s_t q;
  sfr_state_s_t d;

  logic [sfr_pkg::NPIN-1:0] pin_raw;
  logic [sfr_pkg::NPIN-1:0] pin_lvl;
  logic [sfr_pkg::NPIN-1:0] pin_rise;

  // out-of-range settings pulled to the nearest legal value
  function automatic logic [sfr_pkg::DLY_W-1:0] clamp_delay(
    input logic [sfr_pkg::DLY_W-1:0] v);
    if (v < sfr_pkg::DLY_MIN) begin
      return sfr_pkg::DLY_MIN;
    end
    if (v > sfr_pkg::DLY_MAX) begin
      return sfr_pkg::DLY_MAX;
    end
    return v;
  endfunction : clamp_delay

  function automatic logic [sfr_pkg::CNT_W-1:0] clamp_limit(
    input logic [sfr_pkg::CNT_W-1:0] v);
    return (v > sfr_pkg::LIMIT_MAX) ? sfr_pkg::LIMIT_MAX : v;
  endfunction : clamp_limit

  assign pin_raw = {panel_start_pin, sense_select_switch, operator_panel_present,
                    face_reset_pin, panel_reset_pin, term_reset_pin, jog_pin,
                    permissive_pin, start_pin};

  sfr_pin_sync #(
    .W      (sfr_pkg::NPIN)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (pin_raw),
    .level   (pin_lvl),
    .rise    (pin_rise)
  );

  logic start_lvl;
  logic start_rise;
  logic permit;
  logic pstart_rise;
  logic manual_rst;
  logic pu_rst;
  logic clear_ok;
  logic auto_ok;
  logic limit_hit;
  logic panel_fall;
  logic panel_trip;
  logic running;
  logic inhibit;
  logic edge_mode;
  logic go_ramp;
  logic [sfr_pkg::CNT_W-1:0] limit_eff;

  always_comb begin
    start_lvl   = pin_lvl[sfr_pkg::PIN_START];
    start_rise  = pin_rise[sfr_pkg::PIN_START];
    permit      = pin_lvl[sfr_pkg::PIN_PERMIT];
    pstart_rise = pin_rise[sfr_pkg::PIN_PSTART];
    edge_mode   = (q.sense_lvl == sfr_pkg::SENSE_EDGE);
    running     = (q.st == sfr_pkg::ST_RAMP) || (q.st == sfr_pkg::ST_BYPASS)
                  || (q.st == sfr_pkg::ST_JOG);
    inhibit     = (q.cool != '0) || !q.cool_loaded;
    manual_rst  = pin_rise[sfr_pkg::PIN_TRST] | pin_rise[sfr_pkg::PIN_PRST]
                  | pin_rise[sfr_pkg::PIN_FRST];
    // mode decode, single reset after initialisation
    pu_rst      = (reset_mode == sfr_pkg::MODE_POWERUP) && init_done
                  && !q.init_prev && !q.pu_done;
    clear_ok    = (manual_rst | pu_rst) && !fault_cond;
    limit_eff   = clamp_limit(reset_limit);
    limit_hit   = (limit_eff != '0) && (q.rst_cnt >= limit_eff);
    // auto reset once delay done and condition gone
    auto_ok     = (reset_mode == sfr_pkg::MODE_AUTO) && q.trip && q.dly_done
                  && !fault_cond && !limit_hit;
    panel_fall  = q.panel_prev && !pin_lvl[sfr_pkg::PIN_PANEL];
    panel_trip  = panel_fall && (!panel_removable_en || (running && q.from_panel));
    // start acceptance, edge demand in edge mode, whatever the reset mode
    go_ramp     = pstart_rise || start_rise
                  || (!edge_mode && start_lvl
                      && (!q.after_fault || reset_mode == sfr_pkg::MODE_AUTO));
  end

  always_comb begin
    d            = q;
    d.tick       = 1'b0;
    d.init_prev  = init_done;
    d.panel_prev = pin_lvl[sfr_pkg::PIN_PANEL];
    d.sense_lvl  = pin_lvl[sfr_pkg::PIN_SENSE];

    if (q.tick_cnt == sfr_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      d.tick_cnt = '0;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 1'b1;
    end

    if (pu_rst) begin
      d.pu_done = 1'b1;
    end

    // cool-down restored after power-up, then counted down
    if (!q.cool_loaded) begin
      d.cool        = cooldown_restore;
      d.cool_loaded = 1'b1;
    end else if (overload_trip) begin
      d.cool = cooldown_time;
    end else if (q.tick && (q.cool != '0)) begin
      d.cool = q.cool - 1'b1;
    end

    if (q.trip && q.tick && !q.dly_done) begin
      d.dly_cnt  = q.dly_cnt + 1'b1;
      d.dly_done = (q.dly_cnt + 1'b1) >= clamp_delay(reset_delay);
    end

    if (auto_ok) begin
      d.trip    = 1'b0;
      d.rst_cnt = q.rst_cnt + 1'b1;
    end
    if (clear_ok) begin
      d.trip    = 1'b0;
      d.rst_cnt = '0;
    end
    // New trips win over any clear in the same cycle
    if (fault_cond || panel_trip) begin
      if (!q.trip) begin
        d.dly_cnt  = '0;
        d.dly_done = 1'b0;
      end
      d.trip        = 1'b1;
      d.after_fault = 1'b1;
    end else if (!start_lvl) begin
      d.after_fault = 1'b0;
    end

    d.warn = warn_cond;

    unique case (q.st)
      sfr_pkg::ST_STOP: begin
        // permissive and cool-down gate every start
        if (!q.trip && permit && !inhibit) begin
          if (go_ramp) begin
            d.st         = sfr_pkg::ST_RAMP;
            d.from_panel = pstart_rise;
          end else if (pin_lvl[sfr_pkg::PIN_JOG]) begin
            d.st         = sfr_pkg::ST_JOG;
            d.from_panel = 1'b0;
          end
        end
      end
      sfr_pkg::ST_RAMP: begin
        if (at_speed) begin
          d.st      = sfr_pkg::ST_BYPASS;
          d.byp     = '0;
          d.stg_cnt = '0;
          d.cyc_cnt = sfr_pkg::CYC_MIN + sfr_pkg::COOL_W'(q.lfsr[9:0]);
        end
      end
      sfr_pkg::ST_JOG: begin
        if (!pin_lvl[sfr_pkg::PIN_JOG]) begin
          d.st = sfr_pkg::ST_STOP;
        end
      end
      sfr_pkg::ST_BYPASS: begin
        if (q.byp != '1) begin
          if (q.stg_cnt == sfr_pkg::STG_W'(STAGGER_CYCLES - 1)) begin
            d.stg_cnt = '0;
            d.byp     = {q.byp[sfr_pkg::NBYP-2:0], 1'b1};
          end else begin
            d.stg_cnt = q.stg_cnt + 1'b1;
          end
        end else if (q.tick) begin
          if (q.cyc_cnt == '0) begin
            d.byp     = '0;
            d.cyc_cnt = sfr_pkg::CYC_MIN + sfr_pkg::COOL_W'(q.lfsr[9:0]);
          end else begin
            d.cyc_cnt = q.cyc_cnt - 1'b1;
          end
        end
      end
      sfr_pkg::ST_FAULT: begin
        if (!q.trip) begin
          d.st = sfr_pkg::ST_STOP;
        end
      end
    endcase

    // loss of permissive stops; a trip overrides everything
    if (running && !permit) begin
      d.st = sfr_pkg::ST_STOP;
    end
    if (d.trip && (q.st != sfr_pkg::ST_FAULT)) begin
      d.st = sfr_pkg::ST_FAULT;
    end
    if (d.st != sfr_pkg::ST_BYPASS) begin
      d.byp = '0;
    end
    d.ramp_on = (d.st == sfr_pkg::ST_RAMP) || (d.st == sfr_pkg::ST_BYPASS);
    d.jog_on  = (d.st == sfr_pkg::ST_JOG);
    // Registered copy so the inhibit output comes from a flop
    d.inh     = (d.cool != '0) || !d.cool_loaded;

    d.lfsr = q.lfsr[0] ? ((q.lfsr >> 1) ^ sfr_pkg::LFSR_TAPS) : (q.lfsr >> 1);

    // status, warning shown only when not faulted
    unique case (d.st)
      sfr_pkg::ST_RAMP:   d.status = sfr_pkg::STAT_RAMP;
      sfr_pkg::ST_JOG:    d.status = sfr_pkg::STAT_JOG;
      sfr_pkg::ST_BYPASS: d.status = sfr_pkg::STAT_BYPASS;
      sfr_pkg::ST_FAULT:  d.status = sfr_pkg::STAT_FAULT;
      default:            d.status = sfr_pkg::STAT_STOP;
    endcase
    if (warn_cond && (d.st != sfr_pkg::ST_FAULT)) begin
      d.status = sfr_pkg::STAT_WARN;
    end

    if (pw_submit) begin
      if (pw_level == sfr_pkg::LVL_BASIC && pw_value == q.pw_basic) begin
        d.lvl = sfr_pkg::LVL_BASIC;
      end else if (pw_level == sfr_pkg::LVL_ALL && pw_value == q.pw_all) begin
        d.lvl = sfr_pkg::LVL_ALL;
      end else begin
        d.lvl = sfr_pkg::LVL_READ;
      end
    end else if (pw_change && q.lvl == sfr_pkg::LVL_ALL) begin
      if (pw_level == sfr_pkg::LVL_BASIC) begin
        d.pw_basic = pw_value;
      end else if (pw_level == sfr_pkg::LVL_ALL) begin
        d.pw_all = pw_value;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q          <= '0;
      q.st       <= sfr_pkg::ST_STOP;
      q.status   <= sfr_pkg::STAT_STOP;
      q.lfsr     <= sfr_pkg::LFSR_SEED;
      q.inh      <= 1'b1;
      q.pw_basic <= sfr_pkg::PW_RESET;
      q.pw_all   <= sfr_pkg::PW_RESET;
    end else begin
      q <= d;
    end
  end

  assign ramp_running     = q.ramp_on;
  assign jog_running      = q.jog_on;
  assign bypass_close     = q.byp;
  assign motor_status     = q.status;
  assign fault_trip       = q.trip;
  assign warn_active      = q.warn;
  assign sense_is_level   = q.sense_lvl;
  assign auto_reset_count = q.rst_cnt;
  assign cooldown_remain  = q.cool;
  assign restart_inhibit  = q.inh;
  assign access_level     = q.lvl;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_EDGE_HELD_START: assert property (
    edge_mode && q.st == sfr_pkg::ST_STOP && !start_rise && !pstart_rise
    |=> q.st != sfr_pkg::ST_RAMP)
    else $error("Edge mode started without a fresh start edge");
  AST_START_GATED: assert property (
    q.st == sfr_pkg::ST_STOP ##1 q.st == sfr_pkg::ST_RAMP
    |-> $past(permit) && !$past(q.trip) && !$past(inhibit))
    else $error("Start accepted without permissive or while tripped");
  AST_PERMIT_STOP: assert property (
    running && !permit && !fault_cond && !panel_trip |=> q.st == sfr_pkg::ST_STOP)
    else $error("Permissive loss did not stop the motor");
  AST_NO_EARLY_AUTO: assert property (
    q.trip && !q.dly_done && !clear_ok |=> q.trip)
    else $error("Trip cleared before the reset delay expired");
  AST_LIMIT_HOLD: assert property (
    q.trip && limit_hit && !clear_ok |=> q.trip && q.rst_cnt == $past(q.rst_cnt))
    else $error("Auto reset went past the limit");
  AST_MANUAL_ZERO: assert property (
    clear_ok && !fault_cond && !panel_trip |=> q.rst_cnt == '0 && !q.trip)
    else $error("Manual reset did not clear trip and count");
  AST_AUTO_COUNT: assert property (
    auto_ok && !clear_ok |=> q.rst_cnt == $past(q.rst_cnt) + 1'b1)
    else $error("Successful auto reset not counted");
  AST_WARN_DROP: assert property (
    !warn_cond |=> !q.warn ##1 (q.status != sfr_pkg::STAT_WARN || $past(warn_cond)))
    else $error("Warning held after its condition ended");
  AST_PANEL_TRIP: assert property (
    panel_fall && !panel_removable_en |=> q.trip [*2])
    else $error("Panel detach did not trip");
  AST_BYPASS_STAGGER: assert property (
    1'b1 |=> $countones(q.byp) <= $countones($past(q.byp)) + 1)
    else $error("Bypass contactors closed together");

  COV_AUTO_RESET: cover property (auto_ok ##1 q.st == sfr_pkg::ST_STOP);
  COV_BYPASS_FULL: cover property (q.st == sfr_pkg::ST_BYPASS && q.byp == '1);
  COV_PANEL_RUN_TRIP: cover property (panel_trip && running && q.from_panel);

endmodule : sfr_start_ctrl

// ===== design/sfr_pkg.sv
// Purpose: Shared constants and types of the start and fault-reset controller
// Assumes: sys_clk at 250 MHz; time settings arrive in tenths of a second
// Notes:   Long cycle counts are top-level parameters; these are their defaults
package sfr_pkg;

  // Clock and time base
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned TICK_TIME_MS   = 100;
  localparam int unsigned TICK_CYCLES    = TICK_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned STAGGER_TIME_US = 20;
  localparam int unsigned STAGGER_CYCLES = STAGGER_TIME_US * CLK_MHZ;

  // Field widths
  localparam int unsigned TICK_W  = 25;
  localparam int unsigned DLY_W   = 13;
  localparam int unsigned CNT_W   = 14;
  localparam int unsigned COOL_W  = 16;
  localparam int unsigned PW_W    = 16;
  localparam int unsigned STG_W   = 13;
  localparam int unsigned LFSR_W  = 16;
  localparam int unsigned NBYP    = 3;
  localparam int unsigned NPIN    = 9;

  // Setting limits, in tenths of a second or in counts
  localparam logic [DLY_W-1:0]  DLY_MIN   = 13'h0001;
  localparam logic [DLY_W-1:0]  DLY_MAX   = 13'h1770;
  localparam logic [CNT_W-1:0]  LIMIT_MAX = 14'h2710;
  localparam logic [COOL_W-1:0] CYC_MIN   = 16'h0258;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;
  localparam logic [PW_W-1:0]   PW_RESET  = 16'h0000;

  // Synchronised pin positions
  localparam int unsigned PIN_START   = 0;
  localparam int unsigned PIN_PERMIT  = 1;
  localparam int unsigned PIN_JOG     = 2;
  localparam int unsigned PIN_TRST    = 3;
  localparam int unsigned PIN_PRST    = 4;
  localparam int unsigned PIN_FRST    = 5;
  localparam int unsigned PIN_PANEL   = 6;
  localparam int unsigned PIN_SENSE   = 7;
  localparam int unsigned PIN_PSTART  = 8;

  // Reset mode encodings
  localparam logic [1:0] MODE_MANUAL  = 2'h0;
  localparam logic [1:0] MODE_AUTO    = 2'h1;
  localparam logic [1:0] MODE_POWERUP = 2'h2;

  // Edit access levels
  localparam logic [1:0] LVL_READ  = 2'h0;
  localparam logic [1:0] LVL_BASIC = 2'h1;
  localparam logic [1:0] LVL_ALL   = 2'h2;

  // Sense switch: low is edge sensing
  localparam logic SENSE_EDGE = 1'b0;

  typedef enum logic [2:0] {
    ST_STOP, ST_RAMP, ST_JOG, ST_BYPASS, ST_FAULT
  } sfr_state_t;

  typedef enum logic [2:0] {
    STAT_STOP, STAT_RAMP, STAT_JOG, STAT_BYPASS, STAT_FAULT, STAT_WARN
  } sfr_status_t;

endpackage : sfr_pkg

// ===== design/sfr_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter and rise pulse
// Assumes: Inputs are asynchronous pins
// Notes:   Stage one feeds stage two only; level moves when stages 2 and 3 agree
module sfr_pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
  } sfr_sync_t;

  sfr_sync_t q;
  sfr_sync_t d;

  always_comb begin
    d      = q;
    d.s1   = pin_in;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = '0;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i]  = q.s3[i];
        d.rise[i] = q.s3[i] & ~q.lvl[i];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
  assign rise  = q.rise;

endmodule : sfr_pin_sync

// ===== bench/sfr_term_model.sv
// Purpose: Terminal-side model driving start, permissive and reset pins
// Assumes: Requests come from the bench; pins follow one cycle later
// Notes:   Pins are always driven, so no floating level is modelled
module sfr_term_model (
  input  wire logic sys_clk,
  input  wire logic start_req,
  input  wire logic permit_req,
  input  wire logic reset_req,
  output logic      start_pin,
  output logic      permissive_pin,
  output logic      term_reset_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    start_pin = 1'b0;
    permissive_pin = 1'b0;
    term_reset_pin = 1'b0;
  end
  always @(posedge sys_clk) begin
    start_pin <= #1 start_req;
    permissive_pin <= #1 permit_req;
    term_reset_pin <= #1 reset_req;
  end
endmodule : sfr_term_model

// ===== bench/test_start_fault_reset_control.sv
// Purpose: Self-checking bench of the start and fault-reset controller
// Assumes: Short tick of 10 cycles and contactor stagger of 4 cycles
// Notes:   Settle waits are generous since pins pass three sync stages
module test_start_fault_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic st_q = 0, pm_q = 0, rs_q = 0, fault = 0, warn = 0, spd = 0, ovl = 0;
  logic sense = 0, psub = 0;
  logic jg = 1'b0, prs = 1'b0, frs = 1'b0, pst = 1'b0, pnl = 1'b1, prem = 1'b1;
  logic initd = 1'b0, pchg = 1'b0;
  logic [1:0] plvl = 2'h1;
  logic [15:0] pwv = 16'h0000;
  logic [1:0] mode = 2'h0;
  logic [13:0] limit = 14'h0000;
  logic st_p, pm_p, rs_p, ramp, jog, trip, wact, lvl, inh;
  logic [2:0] byp;
  logic [1:0] acc;
  logic [13:0] cnt;
  logic [15:0] crem;
  sfr_pkg::sfr_status_t stat;
  int fail_count = 0, tests_run = 0, cycles = 0;
  sfr_term_model sfr_term_model_inst (.sys_clk(sys_clk), .start_req(st_q), .permit_req(pm_q),
    .reset_req(rs_q), .start_pin(st_p), .permissive_pin(pm_p), .term_reset_pin(rs_p));
  sfr_start_ctrl #(.TICK_CYCLES(10), .STAGGER_CYCLES(4)) sfr_start_ctrl_inst (
    .sys_clk(sys_clk), .rst(rst), .start_pin(st_p), .permissive_pin(pm_p), .jog_pin(jg),
    .term_reset_pin(rs_p), .panel_reset_pin(prs), .face_reset_pin(frs),
    .panel_start_pin(pst), .operator_panel_present(pnl), .sense_select_switch(sense),
    .reset_mode(mode), .reset_delay(13'h0002), .reset_limit(limit),
    .panel_removable_en(prem), .init_done(initd), .fault_cond(fault), .warn_cond(warn),
    .at_speed(spd), .overload_trip(ovl), .cooldown_time(16'h0002),
    .cooldown_restore(16'h0000), .pw_submit(psub), .pw_change(pchg), .pw_level(plvl),
    .pw_value(pwv), .ramp_running(ramp), .jog_running(jog), .bypass_close(byp),
    .motor_status(stat), .fault_trip(trip), .warn_active(wact), .sense_is_level(lvl),
    .auto_reset_count(cnt), .cooldown_remain(crem), .restart_inhibit(inh),
    .access_level(acc));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic reset_press;
    rs_q = 1;
    cyc(8);
    rs_q = 0;
    cyc(8);
  endtask : reset_press
  task automatic t_run;
    pm_q = 1; st_q = 1;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_RAMP));
    chk({14'h0, jog, ramp}, 16'h0001);
    spd = 1;
    cyc(20);
    chk(16'(stat), 16'(sfr_pkg::STAT_BYPASS));
    chk(16'(byp), 16'h0007);
    pm_q = 0;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_STOP));
    pm_q = 1; spd = 0;
    $display("t_run done");
  endtask : t_run
  task automatic t_edge;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_STOP));
    st_q = 0;
    cyc(8);
    st_q = 1;
    cyc(8);
    fault = 1;
    cyc(3);
    chk({14'h0, trip, ramp}, 16'h0002);
    fault = 0;
    cyc(30);
    chk(16'(trip), 16'h0001);
    reset_press();
    chk(16'(stat), 16'(sfr_pkg::STAT_STOP));
    st_q = 0;
    cyc(8);
    st_q = 1;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_RAMP));
    st_q = 0;
    pm_q = 0;
    cyc(8);
    pm_q = 1;
    $display("t_edge done");
  endtask : t_edge
  task automatic t_auto;
    mode = sfr_pkg::MODE_AUTO;
    fault = 1;
    cyc(40);
    chk(16'(trip), 16'h0001);
    fault = 0;
    cyc(4);
    chk({trip, 1'b0, cnt}, 16'h0001);
    limit = 14'h0001;
    fault = 1;
    cyc(2);
    fault = 0;
    cyc(40);
    chk(16'(trip), 16'h0001);
    reset_press();
    chk({trip, 1'b0, cnt}, 16'h0000);
    $display("t_auto done");
  endtask : t_auto
  task automatic t_misc;
    warn = 1;
    cyc(3);
    chk(16'(wact), 16'h0001);
    chk(16'(stat), 16'(sfr_pkg::STAT_WARN));
    warn = 0;
    cyc(3);
    chk(16'(wact), 16'h0000);
    ovl = 1;
    cyc(1);
    chk(16'(crem), 16'h0002);
    ovl = 0;
    cyc(2);
    chk(16'(inh), 16'h0001);
    cyc(30);
    chk(16'(inh), 16'h0000);
    sense = 1; psub = 1;
    cyc(1);
    psub = 0;
    cyc(8);
    chk({lvl, 13'h0, acc}, 16'h8001);
    $display("t_misc done");
  endtask : t_misc
  task automatic t_jog;
    jg = 1'b1;
    cyc(8);
    chk({14'h0, jog, ramp}, 16'h0002);
    chk(16'(stat), 16'(sfr_pkg::STAT_JOG));
    jg = 1'b0;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_STOP));
    $display("t_jog done");
  endtask : t_jog
  task automatic t_level;
    limit = 14'h0000;
    st_q = 1;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_RAMP));
    fault = 1;
    cyc(2);
    fault = 0;
    cyc(40);
    chk(16'(stat), 16'(sfr_pkg::STAT_RAMP));
    sense = 0;
    cyc(8);
    fault = 1;
    cyc(2);
    fault = 0;
    cyc(40);
    chk(16'(stat), 16'(sfr_pkg::STAT_STOP));
    chk(16'(cnt), 16'h0002);
    st_q = 0;
    cyc(8);
    rst = 1;
    cyc(2);
    chk(16'(inh), 16'h0001);
    rst = 0;
    cyc(2);
    chk(16'(cnt), 16'h0000);
    $display("t_level done");
  endtask : t_level
  task automatic t_panel;
    mode = sfr_pkg::MODE_MANUAL;
    pst = 1'b1;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_RAMP));
    pnl = 1'b0;
    cyc(8);
    chk(16'(trip), 16'h0001);
    pnl = 1'b1;
    pst = 1'b0;
    prs = 1'b1;
    cyc(8);
    prs = 1'b0;
    cyc(8);
    chk(16'(trip), 16'h0000);
    prem = 1'b0;
    pnl = 1'b0;
    cyc(8);
    chk(16'(trip), 16'h0001);
    pnl = 1'b1;
    prem = 1'b1;
    frs = 1'b1;
    cyc(8);
    frs = 1'b0;
    cyc(8);
    chk(16'(trip), 16'h0000);
    st_q = 1;
    cyc(8);
    pnl = 1'b0;
    cyc(8);
    chk(16'(stat), 16'(sfr_pkg::STAT_RAMP));
    pnl = 1'b1;
    pm_q = 0;
    st_q = 0;
    cyc(8);
    pm_q = 1;
    cyc(8);
    $display("t_panel done");
  endtask : t_panel
  task automatic t_pwr;
    mode = sfr_pkg::MODE_POWERUP;
    fault = 1;
    cyc(2);
    fault = 0;
    initd = 1'b1;
    cyc(2);
    chk(16'(trip), 16'h0000);
    fault = 1;
    cyc(2);
    fault = 0;
    initd = 1'b0;
    cyc(2);
    initd = 1'b1;
    cyc(4);
    chk(16'(trip), 16'h0001);
    reset_press();
    chk(16'(trip), 16'h0000);
    plvl = 2'h2;
    psub = 1'b1;
    cyc(1);
    psub = 1'b0;
    cyc(1);
    chk(16'(acc), 16'(sfr_pkg::LVL_ALL));
    pchg = 1'b1;
    plvl = 2'h1;
    pwv = 16'h5a5a;
    cyc(1);
    pchg = 1'b0;
    pwv = 16'h0000;
    psub = 1'b1;
    cyc(1);
    psub = 1'b0;
    cyc(1);
    chk(16'(acc), 16'(sfr_pkg::LVL_READ));
    $display("t_pwr done");
  endtask : t_pwr
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    cyc(6);
    rst = 0;
    cyc(2);
    chk(16'(cnt), 16'h0000);
    t_run();
    t_edge();
    t_auto();
    t_misc();
    t_jog();
    t_level();
    t_panel();
    t_pwr();
    stop_test();
  end
endmodule : test_start_fault_reset_control
